//--- two_wire_debug_pkg.sv
// Contract
// [R1] Packet is eight data, parity, acknowledge bits
// [R2] Sender makes data plus parity even ones
// [R3] Receiver pulls acknowledge low when error free
// [R4] Sender treats high acknowledge as failure
// [R5] Host stops and resends a failed command
// [R6] Commands are several packets, never one
// [R7] Start and stop conditions frame each command
// [R8] Exactly two wires: clock in, data bidirectional; the code also pulls the clock low to wait (scl_oe)
// [R9] Both lines open drain, pull low only
// [R10] Halt on break, single step, one breakpoint
// [R11] Works at any core clock rate; the code needs the core clock fast enough to resolve start and stop conditions
// [R12] Conditions change data while clock high
// [R13] Device may hold clock low to wait
package two_wire_debug_pkg;
    localparam int DATA_BITS = 8;
    localparam logic [3:0] BIT_PARITY = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam int PC_BITS = 16;
    localparam logic [15:0] BP_ADDR_RST = 16'h0000;
    localparam logic [7:0] OP_HALT = 8'h01;
    localparam logic [7:0] OP_RUN = 8'h02;
    localparam logic [7:0] OP_STEP = 8'h03;
    localparam logic [7:0] OP_SET_BP = 8'h04;
    localparam logic [7:0] OP_CLR_BP = 8'h05;
    localparam logic [1:0] LEN_SHORT = 2'h2;
    localparam logic [1:0] LEN_BP = 2'h3;
    localparam logic [1:0] LEN_MAX = 2'h3;
endpackage : two_wire_debug_pkg

//--- two_wire_sync.sv
`timescale 1ns/1ps
module two_wire_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic aclr,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock or posedge aclr) begin
        if (aclr) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : two_wire_sync

//--- two_wire_debug_link.sv
`timescale 1ns/1ps
module two_wire_debug_link (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_err,
    output logic cmd_start,
    output logic cmd_stop,
    input wire logic [7:0] tx_byte,
    input wire logic tx_load,
    output logic tx_ready,
    output logic tx_done,
    output logic tx_nak,
    input wire logic busy,
    input wire logic brk_instr,
    input wire logic step_done,
    input wire logic pc_valid,
    input wire logic [15:0] core_pc,
    output logic halted,
    output logic stepping,
    output logic bp_armed
);
    function automatic logic odd_ones(input logic [8:0] v);
        odd_ones = ^v;
    endfunction : odd_ones

    // ---------------- System clock domain ----------------
    logic scl_s, sda_s, pkt_s;
    logic sda_p_q;
    logic link_rst_q, in_cmd_q, pkt_seen_q;
    logic tx_pend_q, tx_tgl_q, err_q, bad_q;
    logic [7:0] tx_data_q;
    logic [1:0] pkt_cnt_q;
    logic [7:0] op_q;
    logic [15:0] arg_q;
    logic [15:0] bp_addr_q;

    // Link-domain words read here only after the packet toggle is seen
    logic [7:0] hold_byte_q;
    logic hold_tx_q, hold_ok_q, pkt_tgl_q;

    two_wire_sync #(.W(2)) u_pin_sync (
        .clock(clock),
        .aclr(1'b0),
        .d({scl_in, sda_in}),
        .q({scl_s, sda_s})
    );

    two_wire_sync #(.W(1)) u_pkt_sync (
        .clock(clock),
        .aclr(1'b0),
        .d(pkt_tgl_q),
        .q(pkt_s)
    );

    wire start_det = scl_s & sda_p_q & ~sda_s; // [R12]
    wire stop_det = scl_s & ~sda_p_q & sda_s; // [R12]
    wire pkt_evt = pkt_s ^ pkt_seen_q;
    wire rx_evt = pkt_evt & ~hold_tx_q;
    wire tx_evt = pkt_evt & hold_tx_q;
    wire load_ok = tx_load & tx_ready;

    // Commands act only at a clean stop with the opcode's packet count, three or more for a breakpoint set
    wire cmd_ok = stop_det & in_cmd_q & ~err_q & ~bad_q; // [R7]
    wire do_halt = cmd_ok & (op_q == two_wire_debug_pkg::OP_HALT)
        & (pkt_cnt_q == two_wire_debug_pkg::LEN_SHORT); // [R6]
    wire do_run = cmd_ok & (op_q == two_wire_debug_pkg::OP_RUN)
        & (pkt_cnt_q == two_wire_debug_pkg::LEN_SHORT); // [R6]
    wire do_step = cmd_ok & (op_q == two_wire_debug_pkg::OP_STEP)
        & (pkt_cnt_q == two_wire_debug_pkg::LEN_SHORT); // [R6]
    wire do_set_bp = cmd_ok & (op_q == two_wire_debug_pkg::OP_SET_BP)
        & (pkt_cnt_q == two_wire_debug_pkg::LEN_BP); // [R6]
    wire do_clr_bp = cmd_ok & (op_q == two_wire_debug_pkg::OP_CLR_BP)
        & (pkt_cnt_q == two_wire_debug_pkg::LEN_SHORT); // [R6]

    wire bp_hit = bp_armed & pc_valid & (core_pc == bp_addr_q); // [R10]
    wire halt_set = brk_instr | (stepping & step_done) | bp_hit | do_halt; // [R10]

    always_ff @(posedge clock) begin
        if (rst) begin
            sda_p_q <= 1'b1;
            link_rst_q <= 1'b1;
            in_cmd_q <= 1'b0;
            cmd_start <= 1'b0;
            cmd_stop <= 1'b0;
        end else if (ce) begin
            sda_p_q <= sda_s;
            cmd_start <= start_det;
            cmd_stop <= stop_det;
            // Link logic is held cleared between frames, so a frame never
            // depends on link clock edges it did not see
            if (start_det) begin
                link_rst_q <= 1'b0; // [R7]
                in_cmd_q <= 1'b1;
            end else if (stop_det) begin
                link_rst_q <= 1'b1; // [R7]
                in_cmd_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pkt_seen_q <= 1'b0;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            rx_err <= 1'b0;
            tx_done <= 1'b0;
            tx_nak <= 1'b0;
        end else if (ce) begin
            pkt_seen_q <= pkt_s;
            rx_valid <= rx_evt & hold_ok_q;
            rx_err <= rx_evt & ~hold_ok_q; // [R3]
            tx_done <= tx_evt & hold_ok_q;
            tx_nak <= tx_evt & ~hold_ok_q; // [R4]
            if (rx_evt) begin
                rx_byte <= hold_byte_q;
            end
        end
    end

    // Transmit hand-off; tx_data_q changes only while nothing is pending
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_pend_q <= 1'b0;
            tx_tgl_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_ready <= 1'b0;
            err_q <= 1'b0;
        end else if (ce) begin
            if (stop_det) begin
                tx_pend_q <= 1'b0;
                tx_tgl_q <= 1'b0;
            end else if (load_ok) begin
                tx_pend_q <= 1'b1;
                tx_tgl_q <= ~tx_tgl_q;
                tx_data_q <= tx_byte;
            end else if (tx_evt) begin
                tx_pend_q <= 1'b0;
            end
            // A failed packet blocks further sends until the host sends a stop or a start
            if (tx_evt & ~hold_ok_q) begin
                err_q <= 1'b1; // [R4]
            end else if (stop_det | start_det) begin
                err_q <= 1'b0; // [R5]
            end
            tx_ready <= ~tx_pend_q & ~load_ok & ~err_q & ~stop_det;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pkt_cnt_q <= 2'h0;
            op_q <= 8'h00;
            arg_q <= 16'h0000;
            bad_q <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                pkt_cnt_q <= 2'h0;
                bad_q <= 1'b0;
            end else if (rx_evt) begin
                if (!hold_ok_q) begin
                    bad_q <= 1'b1;
                end
                if (pkt_cnt_q == 2'h0) begin
                    op_q <= hold_byte_q;
                end else begin
                    arg_q <= {arg_q[7:0], hold_byte_q};
                end
                if (pkt_cnt_q != two_wire_debug_pkg::LEN_MAX) begin
                    pkt_cnt_q <= pkt_cnt_q + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            halted <= 1'b0;
            stepping <= 1'b0;
            bp_armed <= 1'b0;
            bp_addr_q <= two_wire_debug_pkg::BP_ADDR_RST;
        end else if (ce) begin
            // A halt cause in the same cycle as run or step wins
            if (halt_set) begin
                halted <= 1'b1; // [R10]
            end else if (do_run | do_step) begin
                halted <= 1'b0;
            end
            if (do_step) begin
                stepping <= 1'b1; // [R10]
            end else if (step_done) begin
                stepping <= 1'b0;
            end
            if (do_set_bp) begin
                bp_addr_q <= arg_q;
                bp_armed <= 1'b1; // [R10]
            end else if (do_clr_bp) begin
                bp_armed <= 1'b0;
            end
        end
    end

    // Stretch only from a low clock so the host never sees a short high
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_oe <= 1'b0;
        end else if (ce) begin
            scl_oe <= busy & in_cmd_q & (~scl_s | scl_oe); // [R13]
        end
    end

    assign scl_out = 1'b0; // [R9]
    assign sda_out = 1'b0; // [R9]

    // ---------------- Link clock domain ----------------
    // Runs on the host clock line itself, so the core clock rate only has
    // to resolve start and stop conditions, not individual bits
    logic [3:0] bit_q; // [R11]
    logic [7:0] shift_q;
    logic par_q, txm_q, tx_seen_q, tx_tgl_s;

    two_wire_sync #(.W(1)) u_tx_sync (
        .clock(link_clk),
        .aclr(link_rst_q),
        .d(tx_tgl_q),
        .q(tx_tgl_s)
    );

    wire par_ok = ~odd_ones({shift_q, par_q}); // [R2]
    wire txm_now = (bit_q == two_wire_debug_pkg::BIT_FIRST) ? (tx_tgl_s ^ tx_seen_q) : txm_q;
    wire tx_par = odd_ones({1'b0, tx_data_q}); // [R2]
    wire [2:0] tx_idx = 3'h7 - bit_q[2:0];
    wire tx_bit = (bit_q == two_wire_debug_pkg::BIT_PARITY) ? tx_par : tx_data_q[tx_idx];
    wire drive_low = txm_now ? ((bit_q != two_wire_debug_pkg::BIT_ACK) & ~tx_bit)
        : ((bit_q == two_wire_debug_pkg::BIT_ACK) & par_ok); // [R3]

    always_ff @(posedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            bit_q <= two_wire_debug_pkg::BIT_FIRST;
            shift_q <= 8'h00;
            par_q <= 1'b0;
            tx_seen_q <= 1'b0;
        end else if (bit_q == two_wire_debug_pkg::BIT_ACK) begin
            bit_q <= two_wire_debug_pkg::BIT_FIRST; // [R1]
            tx_seen_q <= tx_seen_q ^ txm_q;
        end else begin
            bit_q <= bit_q + 4'h1; // [R1]
            if (bit_q == two_wire_debug_pkg::BIT_PARITY) begin
                par_q <= sda_in;
            end else begin
                shift_q <= {shift_q[6:0], sda_in};
            end
        end
    end

    // Packet results are held here until the next packet ends
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            pkt_tgl_q <= 1'b0;
            hold_byte_q <= 8'h00;
            hold_tx_q <= 1'b0;
            hold_ok_q <= 1'b0;
        end else if (!link_rst_q && bit_q == two_wire_debug_pkg::BIT_ACK) begin
            pkt_tgl_q <= ~pkt_tgl_q;
            hold_byte_q <= shift_q;
            hold_tx_q <= txm_q;
            hold_ok_q <= txm_q ? ~sda_in : par_ok; // [R4]
        end
    end

    always_ff @(negedge link_clk or posedge link_rst_q) begin
        if (link_rst_q) begin
            txm_q <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            txm_q <= txm_now;
            // Data moves only on the falling edge, while the clock is low
            sda_oe <= drive_low; // [R12]
        end
    end
endmodule : two_wire_debug_link

//--- two_wire_debug_link_asserts.sv
`timescale 1ns/1ps
module two_wire_debug_link_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic busy,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic scl_oe,
    input wire logic rx_valid,
    input wire logic rx_err,
    input wire logic cmd_start,
    input wire logic tx_load,
    input wire logic tx_ready,
    input wire logic tx_done,
    input wire logic tx_nak,
    input wire logic brk_instr,
    input wire logic halted
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_take;
        ce && tx_load && tx_ready;
    endsequence
    sequence s_idle2;
        (ce && !busy) [*2];
    endsequence
    property p_pins; !scl_out && !sda_out; endproperty
    a_pins: assert property (p_pins) else $error("pin driven high");
    property p_rx_one; !(rx_valid && rx_err); endproperty
    a_rx_one: assert property (p_rx_one) else $error("good and bad byte");
    property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("byte pulse long");
    property p_start; cmd_start |=> !cmd_start; endproperty
    a_start: assert property (p_start) else $error("start pulse long");
    property p_take; s_take |=> !tx_ready; endproperty
    a_take: assert property (p_take) else $error("load not taken");
    property p_nak; tx_nak |=> (!tx_ready) [*3]; endproperty
    a_nak: assert property (p_nak) else $error("ready after failure");
    property p_tx_one; !(tx_done && tx_nak); endproperty
    a_tx_one: assert property (p_tx_one) else $error("done and failed");
    property p_brk; brk_instr && ce |=> halted; endproperty
    a_brk: assert property (p_brk) else $error("break did not halt");
    property p_wait; s_idle2 |-> !scl_oe; endproperty
    a_wait: assert property (p_wait) else $error("clock held while idle");
endmodule : two_wire_debug_link_asserts

//--- debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model (
    output logic h_scl,
    output logic h_sda,
    input wire logic scl_in,
    input wire logic sda_in
);
    // Both lines released at rest, so the clock stands high between frames
    initial begin
        h_scl = 1'b0;
        h_sda = 1'b0;
    end
    task automatic cond(input logic start);
        h_scl = 1'b1;
        #30 h_sda = !start;
        #30 h_scl = 1'b0;
        #60 h_sda = start;
        #150;
    endtask : cond
    // A one releases the line; the model only ever pulls low
    task automatic packet(input logic [9:0] drv, output logic [9:0] seen);
        for (int i = 9; i >= 0; i--) begin
            h_scl = 1'b1;
            #20 h_sda = !drv[i];
            #42.5 h_scl = 1'b0;
            wait (scl_in);
            #10 seen[i] = sda_in;
            #52.5;
        end
    endtask : packet
endmodule : debug_host_model

//--- two_wire_debug_link_tb.sv
`timescale 1ns/1ps
module two_wire_debug_link_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic tx_load = 1'b0;
    logic busy = 1'b0;
    logic brk_instr = 1'b0;
    logic step_done = 1'b0;
    logic pc_valid = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [15:0] core_pc = 16'h0000;
    logic scl_out, scl_oe, sda_out, sda_oe, rx_valid, rx_err, cmd_start, cmd_stop, tx_ready;
    logic tx_done, tx_nak, halted, stepping, bp_armed, h_scl, h_sda;
    logic [7:0] rx_byte;
    logic [15:0] cnt [6] = '{default: 16'h0000};
    logic [15:0] c0 [6];
    logic saw_wait = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    // Wired-AND: the pull-up wins only when neither party pulls
    wire scl_in = !(scl_oe && !scl_out) && !h_scl;
    wire link_clk = scl_in;
    wire sda_in = !(sda_oe && !sda_out) && !h_sda;
    wire [5:0] pulses = {cmd_stop, cmd_start, tx_nak, tx_done, rx_err, rx_valid};
    two_wire_debug_link u_dut (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .link_clk(link_clk),
        .scl_in(scl_in),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .rx_err(rx_err),
        .cmd_start(cmd_start),
        .cmd_stop(cmd_stop),
        .tx_byte(tx_byte),
        .tx_load(tx_load),
        .tx_ready(tx_ready),
        .tx_done(tx_done),
        .tx_nak(tx_nak),
        .busy(busy),
        .brk_instr(brk_instr),
        .step_done(step_done),
        .pc_valid(pc_valid),
        .core_pc(core_pc),
        .halted(halted),
        .stepping(stepping),
        .bp_armed(bp_armed)
    );
    debug_host_model u_host (
        .h_scl(h_scl),
        .h_sda(h_sda),
        .scl_in(scl_in),
        .sda_in(sda_in)
    );
    initial begin
        forever #12.5 clock = !clock;
    end
    always @(posedge clock) begin
        for (int i = 0; i < 6; i++) begin
            cnt[i] <= cnt[i] + 16'(pulses[i]);
        end
        saw_wait <= saw_wait || scl_oe;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic dcnt(input int i, input logic [15:0] e);
        check("pulses", cnt[i] - c0[i], e);
    endtask : dcnt
    // The last byte may carry a wrong parity to provoke a refusal
    task automatic cmd(input logic [23:0] b, input int n, input logic good);
        logic [9:0] s;
        logic [7:0] v;
        logic bad;
        c0 = cnt;
        u_host.cond(1'b1);
        for (int k = 0; k < n; k++) begin
            v = b[23 - 8 * k -: 8];
            bad = (k == n - 1) && !good;
            u_host.packet({v, ^v ^ bad, 1'b1}, s);
            check("ack", 16'(s[0]), 16'(bad));
        end
        u_host.cond(1'b0);
        repeat (8) @(posedge clock);
        dcnt(4, 16'h0001);
        dcnt(5, 16'h0001);
    endtask : cmd
    task automatic core_evt(input logic brk);
        @(posedge clock);
        brk_instr <= brk;
        step_done <= !brk;
        @(posedge clock);
        brk_instr <= 1'b0;
        step_done <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : core_evt
    task automatic t_parity();
        cmd({two_wire_debug_pkg::OP_HALT, 16'h0000}, 2, 1'b0);
        dcnt(1, 16'h0001);
        check("halted", 16'(halted), 16'h0000);
        cmd({two_wire_debug_pkg::OP_HALT, 16'h5A00}, 2, 1'b1);
        check("halted", 16'(halted), 16'h0001);
        check("byte", 16'(rx_byte), 16'h005A);
        dcnt(0, 16'h0002);
        cmd({two_wire_debug_pkg::OP_RUN, 16'h0000}, 2, 1'b1);
        check("halted", 16'(halted), 16'h0000);
    endtask : t_parity
    task automatic t_cmds();
        cmd({two_wire_debug_pkg::OP_HALT, 16'h0000}, 1, 1'b1);
        check("halted", 16'(halted), 16'h0000);
        cmd({two_wire_debug_pkg::OP_SET_BP, 16'h1234}, 3, 1'b1);
        check("armed", 16'(bp_armed), 16'h0001);
        @(posedge clock);
        pc_valid <= 1'b1;
        core_pc <= 16'h1234;
        @(posedge clock);
        pc_valid <= 1'b0;
        repeat (2) @(posedge clock);
        check("halted", 16'(halted), 16'h0001);
        cmd({two_wire_debug_pkg::OP_CLR_BP, 16'h0000}, 2, 1'b1);
        check("armed", 16'(bp_armed), 16'h0000);
        cmd({two_wire_debug_pkg::OP_STEP, 16'h0000}, 2, 1'b1);
        check("run step", 16'({halted, stepping}), 16'h0001);
        core_evt(1'b0);
        check("step end", 16'({halted, stepping}), 16'h0002);
        cmd({two_wire_debug_pkg::OP_RUN, 16'h0000}, 2, 1'b1);
        core_evt(1'b1);
        check("halted", 16'(halted), 16'h0001);
    endtask : t_cmds
    // An opcode packet first gives the loaded byte link edges to settle
    task automatic t_tx(input logic [7:0] v, input logic nak);
        logic [9:0] s;
        c0 = cnt;
        u_host.cond(1'b1);
        @(posedge clock);
        tx_byte <= v;
        tx_load <= 1'b1;
        @(posedge clock);
        tx_load <= 1'b0;
        u_host.packet({8'h10, 2'h3}, s);
        u_host.packet({9'h1FF, nak}, s);
        repeat (8) @(posedge clock);
        check("tx bits", 16'(s[9:1]), 16'({v, ^v}));
        dcnt(2, 16'(!nak));
        dcnt(3, 16'(nak));
        check("ready", 16'(tx_ready), 16'(!nak));
        u_host.cond(1'b0);
        repeat (8) @(posedge clock);
        check("ready", 16'(tx_ready), 16'h0001);
    endtask : t_tx
    // A low enable must swallow a core break event entirely
    task automatic t_freeze();
        cmd({two_wire_debug_pkg::OP_RUN, 16'h0000}, 2, 1'b1);
        @(posedge clock);
        ce <= 1'b0;
        brk_instr <= 1'b1;
        @(posedge clock);
        brk_instr <= 1'b0;
        repeat (2) @(posedge clock);
        check("frozen", 16'(halted), 16'h0000);
        ce <= 1'b1;
        repeat (2) @(posedge clock);
        check("thawed", 16'(halted), 16'h0000);
    endtask : t_freeze
    task automatic t_wait();
        check("no wait", 16'(saw_wait), 16'h0000);
        @(posedge clock);
        busy <= 1'b1;
        fork
            cmd({two_wire_debug_pkg::OP_HALT, 16'h0000}, 2, 1'b1);
            begin
                repeat (120) @(posedge clock);
                busy <= 1'b0;
            end
        join
        check("wait", 16'({saw_wait, scl_oe}), 16'h0002);
    endtask : t_wait
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_parity();
        t_cmds();
        t_freeze();
        t_tx(8'hA5, 1'b0);
        t_tx(8'h3C, 1'b1);
        t_wait();
        report_and_stop();
    end
    // Whole run is near 43 us; about fourteen times that means a hang
    initial begin
        #600_000;
        error_cnt++;
        report_and_stop();
    end
endmodule : two_wire_debug_link_tb
bind two_wire_debug_link two_wire_debug_link_asserts u_chk (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .busy(busy),
    .scl_out(scl_out),
    .sda_out(sda_out),
    .scl_oe(scl_oe),
    .rx_valid(rx_valid),
    .rx_err(rx_err),
    .cmd_start(cmd_start),
    .tx_load(tx_load),
    .tx_ready(tx_ready),
    .tx_done(tx_done),
    .tx_nak(tx_nak),
    .brk_instr(brk_instr),
    .halted(halted)
);
